// ===== ofs_defs.svh
// Constants and register map of the output function selector
// Behaviour
// - Code 5 drives output on motor overload
// - Code 6 drives output on inverse-time overload trip
// - Code 7 drives output on underload warning
// - Code 8 drives output on fan warning
// - Code 9 drives output on overload plus stall
// - Code 10 drives output on DC overvoltage
// - Code 11 drives output on DC undervoltage
// - Code 12 drives output on drive overheat
// - Code 13 drives output on lost command
// - Code 14 runs with voltage, off in DC braking
// - Code 15 drives output when stopped, no voltage
// - Code 16 drives output at steady speed
// - Code 17 drives output on drive line
// - Code 18 drives output on mains line
// - Code 19 drives output during speed search
// - Code 22 drives output when ready
// - Code 28 drives output after timer delay
// - Code 29 drives output after fault trip
// - Code 34 follows analog threshold comparison
// - Code 35 drives brake release signal
// - Code 40 drives output during energy buffering
// - Status register shows one bit per output
`ifndef OFS_DEFS_SVH
`define OFS_DEFS_SVH
`define OFS_ADDR_RELAY1_SEL   12'h000
`define OFS_ADDR_RELAY2_SEL   12'h004
`define OFS_ADDR_TR_SEL       12'h008
`define OFS_ADDR_DO_STATUS    12'h00c
`define OFS_ADDR_TIMER_DLY    12'h010
`define OFS_ADDR_AN_ON_LVL    12'h014
`define OFS_ADDR_AN_OFF_LVL   12'h018
`define OFS_RST_RELAY1_SEL    6'h1d
`define OFS_RST_RELAY2_SEL    6'h0e
`define OFS_RST_TR_SEL        6'h0e
`define OFS_RST_TIMER_DLY     24'h000000
`define OFS_RST_AN_ON_LVL     12'h800
`define OFS_RST_AN_OFF_LVL    12'h400
`define OFS_SEL_W             6
`define OFS_DLY_W             24
`define OFS_AN_W              12
`define OFS_NUM_OUT           3
`endif

// ===== ofs_pkg.sv
// Types of the output function selector
package ofs_pkg;
    typedef enum logic [5:0] {
        OFS_FN_NONE      = 6'h00,
        OFS_FN_OVERLOAD  = 6'h05,
        OFS_FN_IOL_TRIP  = 6'h06,
        OFS_FN_UNDERLOAD = 6'h07,
        OFS_FN_FAN_WARN  = 6'h08,
        OFS_FN_STALL     = 6'h09,
        OFS_FN_OVER_VOLT = 6'h0a,
        OFS_FN_LOW_VOLT  = 6'h0b,
        OFS_FN_OVER_HEAT = 6'h0c,
        OFS_FN_LOST_CMD  = 6'h0d,
        OFS_FN_RUN       = 6'h0e,
        OFS_FN_STOP      = 6'h0f,
        OFS_FN_STEADY    = 6'h10,
        OFS_FN_DRV_LINE  = 6'h11,
        OFS_FN_MAIN_LINE = 6'h12,
        OFS_FN_SPD_SRCH  = 6'h13,
        OFS_FN_READY     = 6'h16,
        OFS_FN_TIMER_OUT = 6'h1c,
        OFS_FN_TRIP      = 6'h1d,
        OFS_FN_ONOFF     = 6'h22,
        OFS_FN_BRAKE     = 6'h23,
        OFS_FN_KEB       = 6'h28
    } ofs_fn_t;

    // Internal drive conditions, one bit each
    typedef struct packed {
        logic motor_overload;
        logic inverse_time_overload_trip;
        logic underload_warn;
        logic fan_warn;
        logic stall;
        logic dc_over_volt;
        logic dc_under_volt;
        logic over_heat;
        logic analog_cmd_lost;
        logic comm_cmd_lost;
        logic card_cmd_lost;
        logic run_cmd;
        logic output_volt_on;
        logic dc_braking;
        logic accelerating;
        logic decelerating;
        logic drive_line;
        logic mains_line;
        logic speed_search;
        logic ready;
        logic timer_trigger;
        logic fault_trip;
        logic brake_release_output;
        logic energy_buffering_active;
    } ofs_cond_t;
endpackage

// ===== ofs_fn_mux.sv
// One output selector: function code to output level
`timescale 1ns/10ps
module ofs_fn_mux (
    // Selection
    input  wire logic [5:0]       sel,
    // Conditions
    input  wire ofs_pkg::ofs_cond_t cond,
    input  wire logic             timer_done,
    input  wire logic             analog_on,
    // Result
    output logic                  level
);
    always_comb begin
        case (sel)
            ofs_pkg::OFS_FN_OVERLOAD:  level = cond.motor_overload;
            ofs_pkg::OFS_FN_IOL_TRIP:
                level = cond.inverse_time_overload_trip;
            ofs_pkg::OFS_FN_UNDERLOAD: level = cond.underload_warn;
            ofs_pkg::OFS_FN_FAN_WARN:  level = cond.fan_warn;
            ofs_pkg::OFS_FN_STALL:
                level = cond.motor_overload & cond.stall;
            ofs_pkg::OFS_FN_OVER_VOLT: level = cond.dc_over_volt;
            ofs_pkg::OFS_FN_LOW_VOLT:  level = cond.dc_under_volt;
            ofs_pkg::OFS_FN_OVER_HEAT: level = cond.over_heat;
            ofs_pkg::OFS_FN_LOST_CMD:
                level = cond.analog_cmd_lost | cond.comm_cmd_lost
                      | cond.card_cmd_lost;
            ofs_pkg::OFS_FN_RUN:
                level = cond.run_cmd & cond.output_volt_on
                      & ~cond.dc_braking;
            ofs_pkg::OFS_FN_STOP:
                level = ~cond.run_cmd & ~cond.output_volt_on;
            ofs_pkg::OFS_FN_STEADY:
                level = cond.run_cmd & cond.output_volt_on
                      & ~cond.accelerating & ~cond.decelerating;
            ofs_pkg::OFS_FN_DRV_LINE:  level = cond.drive_line;
            ofs_pkg::OFS_FN_MAIN_LINE: level = cond.mains_line;
            ofs_pkg::OFS_FN_SPD_SRCH:  level = cond.speed_search;
            ofs_pkg::OFS_FN_READY:     level = cond.ready;
            ofs_pkg::OFS_FN_TIMER_OUT: level = timer_done;
            ofs_pkg::OFS_FN_TRIP:      level = cond.fault_trip;
            ofs_pkg::OFS_FN_ONOFF:     level = analog_on;
            ofs_pkg::OFS_FN_BRAKE:
                level = cond.brake_release_output;
            ofs_pkg::OFS_FN_KEB:
                level = cond.energy_buffering_active;
            default:                   level = 1'b0;
        endcase
    end
endmodule

// ===== ofs_output_function_selector.sv
// Top of the output function selector with its APB register file
`timescale 1ns/10ps
`include "ofs_defs.svh"
module ofs_output_function_selector #(
    parameter int DLY_W = `OFS_DLY_W,
    parameter int AN_W  = `OFS_AN_W
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Drive conditions, asynchronous to pclk
    input  wire ofs_pkg::ofs_cond_t cond_in,
    input  wire logic [AN_W-1:0]  analog_value,
    // Outputs
    output logic                  relay1_out,
    output logic                  relay2_out,
    output logic                  transistor_output
);
    localparam int NO = `OFS_NUM_OUT;

    // Registers
    logic [5:0]        sel_q [NO];
    logic [DLY_W-1:0]  timer_dly_q;
    logic [AN_W-1:0]   an_on_q;
    logic [AN_W-1:0]   an_off_q;
    logic [NO-1:0]     out_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;

    // Synchronisers
    ofs_pkg::ofs_cond_t cond_s1_q;
    ofs_pkg::ofs_cond_t cond_s2_q;
    logic [AN_W-1:0]   an_s1_q;
    logic [AN_W-1:0]   an_s2_q;
    logic [AN_W-1:0]   an_s3_q;

    // Timer and comparator state
    logic [DLY_W-1:0]  tmr_cnt_q;
    logic              timer_done_q;
    logic              analog_on_q;

    logic [NO-1:0]     level;
    logic              setup_ph;
    logic              acc_ph;
    logic              wr_en;
    logic              addr_ok;

    // Merge write data under byte strobes
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        logic m;
        m = 1'b0;
        if (a == `OFS_ADDR_RELAY1_SEL) begin
            m = 1'b1;
        end else if (a == `OFS_ADDR_RELAY2_SEL) begin
            m = 1'b1;
        end else if (a == `OFS_ADDR_TR_SEL) begin
            m = 1'b1;
        end else if (a == `OFS_ADDR_DO_STATUS) begin
            m = 1'b1;
        end else if (a == `OFS_ADDR_TIMER_DLY) begin
            m = 1'b1;
        end else if (a == `OFS_ADDR_AN_ON_LVL) begin
            m = 1'b1;
        end else if (a == `OFS_ADDR_AN_OFF_LVL) begin
            m = 1'b1;
        end
        return m;
    endfunction

    // No wait state: answer in the first access cycle after setup
    assign setup_ph = psel & ~penable;
    assign acc_ph   = psel & penable & pready_q;
    assign addr_ok  = addr_mapped(paddr);
    assign wr_en    = acc_ph & pwrite & addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph & ~addr_mapped(paddr);
        end
    end

    // Selector registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q[0] <= `OFS_RST_RELAY1_SEL;
            sel_q[1] <= `OFS_RST_RELAY2_SEL;
            sel_q[2] <= `OFS_RST_TR_SEL;
        end else if (wr_en) begin
            if (paddr == `OFS_ADDR_RELAY1_SEL) begin
                sel_q[0] <= 6'(strb_merge({26'h0, sel_q[0]}, pwdata, pstrb));
            end else if (paddr == `OFS_ADDR_RELAY2_SEL) begin
                sel_q[1] <= 6'(strb_merge({26'h0, sel_q[1]}, pwdata, pstrb));
            end else if (paddr == `OFS_ADDR_TR_SEL) begin
                sel_q[2] <= 6'(strb_merge({26'h0, sel_q[2]}, pwdata, pstrb));
            end
        end
    end

    // Timer delay and analog thresholds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_dly_q <= DLY_W'(`OFS_RST_TIMER_DLY);
            an_on_q     <= AN_W'(`OFS_RST_AN_ON_LVL);
            an_off_q    <= AN_W'(`OFS_RST_AN_OFF_LVL);
        end else if (wr_en) begin
            if (paddr == `OFS_ADDR_TIMER_DLY) begin
                timer_dly_q <= DLY_W'(strb_merge(32'(timer_dly_q), pwdata,
                                                 pstrb));
            end else if (paddr == `OFS_ADDR_AN_ON_LVL) begin
                an_on_q <= AN_W'(strb_merge(32'(an_on_q), pwdata, pstrb));
            end else if (paddr == `OFS_ADDR_AN_OFF_LVL) begin
                an_off_q <= AN_W'(strb_merge(32'(an_off_q), pwdata, pstrb));
            end
        end
    end

    // Read data, captured during setup so it stands in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup_ph & ~pwrite) begin
            if (paddr == `OFS_ADDR_RELAY1_SEL) begin
                prdata_q <= {26'h0, sel_q[0]};
            end else if (paddr == `OFS_ADDR_RELAY2_SEL) begin
                prdata_q <= {26'h0, sel_q[1]};
            end else if (paddr == `OFS_ADDR_TR_SEL) begin
                prdata_q <= {26'h0, sel_q[2]};
            end else if (paddr == `OFS_ADDR_DO_STATUS) begin
                prdata_q <= {29'h0, out_q};
            end else if (paddr == `OFS_ADDR_TIMER_DLY) begin
                prdata_q <= 32'(timer_dly_q);
            end else if (paddr == `OFS_ADDR_AN_ON_LVL) begin
                prdata_q <= 32'(an_on_q);
            end else if (paddr == `OFS_ADDR_AN_OFF_LVL) begin
                prdata_q <= 32'(an_off_q);
            end else begin
                prdata_q <= 32'h0;
            end
        end
    end

    // Conditions arrive from other logic: two flip-flops each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_s1_q <= '0;
            cond_s2_q <= '0;
        end else begin
            cond_s1_q <= cond_in;
            cond_s2_q <= cond_s1_q;
        end
    end

    // Analog word passes three flip-flops and is used only when the last two samples agree,
    // since a multi-bit bus may be caught mid-change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_s1_q <= '0;
            an_s2_q <= '0;
            an_s3_q <= '0;
        end else begin
            an_s1_q <= analog_value;
            an_s2_q <= an_s1_q;
            an_s3_q <= an_s2_q;
        end
    end

    // Hysteresis comparator; on level above off level gives a band
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_on_q <= 1'b0;
        end else if (an_s2_q == an_s3_q) begin
            if (an_s2_q >= an_on_q) begin
                analog_on_q <= 1'b1;
            end else if (an_s2_q <= an_off_q) begin
                analog_on_q <= 1'b0;
            end
        end
    end

    // Delay after the timer input; drops as soon as the input drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_cnt_q    <= '0;
            timer_done_q <= 1'b0;
        end else if (!cond_s2_q.timer_trigger) begin
            tmr_cnt_q    <= '0;
            timer_done_q <= 1'b0;
        end else if (tmr_cnt_q >= timer_dly_q) begin
            timer_done_q <= 1'b1;
        end else begin
            tmr_cnt_q <= tmr_cnt_q + DLY_W'(1);
        end
    end

    // Each output has its own selector
    for (genvar i = 0; i < NO; i++) begin : g_sel
        ofs_fn_mux u_mux (
            .sel        (sel_q[i]),
            .cond       (cond_s2_q),
            .timer_done (timer_done_q),
            .analog_on  (analog_on_q),
            .level      (level[i])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else begin
            out_q <= level;
        end
    end

    assign relay1_out        = out_q[0];
    assign relay2_out        = out_q[1];
    assign transistor_output = out_q[2];
    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
endmodule

// ===== ofs_checker_asserts.sv
// Port-level checks of the output function selector
`timescale 1ns/10ps
module ofs_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Outputs
    input wire logic        relay1_out,
    input wire logic        relay2_out,
    input wire logic        transistor_output
);
    logic [2:0] outs;
    logic       mapped;
    assign outs   = {transistor_output, relay2_out, relay1_out};
    assign mapped = (paddr <= 12'h018) && (paddr[1:0] == 2'b00);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer in the access cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped address not flagged");
    mapped_ok_a: assert property (pready && mapped && !pwrite |-> !pslverr)
        else $error("mapped read flagged as error");
    err_zero_a: assert property (pready && pslverr && !pwrite |->
        prdata == 32'h0) else $error("unmapped read not zero");
    status_view_a: assert property (pready && !pwrite && paddr == 12'h00c
        && $stable(outs) |-> prdata == {29'h0, outs})
        else $error("status differs from outputs");
    reset_low_a: assert property ($rose(presetn) |-> outs == 3'b000)
        else $error("output high right after reset");
endmodule

// ===== ofs_load_model.sv
// Loads wired to the outputs: relay coils and a controller input
`timescale 1ns/10ps
module ofs_load_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Outputs of the block
    input  wire logic       relay1_out,
    input  wire logic       relay2_out,
    input  wire logic       transistor_output,
    // Contact state seen by the load
    output logic      [2:0] contacts
);
    // Contacts pick up one cycle late, as a real coil never closes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contacts <= 3'b000;
        end else begin
            contacts <= {transistor_output, relay2_out, relay1_out};
        end
    end
endmodule

// ===== ofs_testbench.sv
// Testbench of the output function selector
`timescale 1ns/10ps
module testbench;
    logic               pclk, presetn, psel, penable, pwrite, err;
    logic [11:0]        paddr, analog_value;
    logic [31:0]        pwdata, prdata, rd;
    logic [3:0]         pstrb;
    logic               pready, pslverr;
    logic               relay1_out, relay2_out, transistor_output;
    logic [2:0]         contacts;
    ofs_pkg::ofs_cond_t cond_in;
    int                 failures, samples_checked, cycles;

    ofs_output_function_selector u_ofs_output_function_selector (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cond_in(cond_in), .analog_value(analog_value),
        .relay1_out(relay1_out), .relay2_out(relay2_out),
        .transistor_output(transistor_output));
    ofs_load_model u_ofs_load_model (
        .pclk(pclk), .presetn(presetn), .relay1_out(relay1_out),
        .relay2_out(relay2_out), .transistor_output(transistor_output),
        .contacts(contacts));

    always #4 pclk = ~pclk;

    // Ceiling well above the under one thousand cycles the sequence needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            stop_test();
        end
    end

    task stop_test();
        $display("checks=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task set_sel(input logic [5:0] c);
        apb(1'b1, 12'h000, {26'h0, c});
        apb(1'b1, 12'h004, {26'h0, c});
        apb(1'b1, 12'h008, {26'h0, c});
    endtask

    task wait_out(input logic [23:0] m, input logic [11:0] an, input int n,
                  input logic [2:0] e);
        cond_in      <= ofs_pkg::ofs_cond_t'(m);
        analog_value <= an;
        repeat (n) @(posedge pclk);
        #1;
        chk({29'h0, transistor_output, relay2_out, relay1_out}, {29'h0, e});
        chk({29'h0, contacts}, {29'h0, e});
        // Back on an edge so the next stimulus lands on a rising edge
        @(posedge pclk);
    endtask

    // Same code on all three outputs, then status read back
    task run_fn(input logic [5:0] c, input logic [23:0] m, input logic e);
        set_sel(c);
        wait_out(m, 12'h000, 5, {3{e}});
        rdchk(12'h00c, {29'h0, {3{e}}});
    endtask

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
        cond_in = ofs_pkg::ofs_cond_t'(24'h0); analog_value = 12'h000;
        failures = 0; samples_checked = 0; cycles = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(12'h000, 32'h1d);
        rdchk(12'h004, 32'h0e);
        rdchk(12'h008, 32'h0e);
        rdchk(12'h010, 32'h0);
        rdchk(12'h014, 32'h800);
        rdchk(12'h018, 32'h400);
        apb(1'b0, 12'h01c, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        run_fn(6'h05, 24'h800000, 1'b1);
        run_fn(6'h05, 24'h7fffff, 1'b0);
        run_fn(6'h06, 24'h400000, 1'b1);
        run_fn(6'h07, 24'h200000, 1'b1);
        run_fn(6'h08, 24'h100000, 1'b1);
        run_fn(6'h09, 24'h880000, 1'b1);
        run_fn(6'h09, 24'h080000, 1'b0);
        run_fn(6'h0a, 24'h040000, 1'b1);
        run_fn(6'h0b, 24'h020000, 1'b1);
        run_fn(6'h0c, 24'h010000, 1'b1);
        run_fn(6'h0d, 24'h008000, 1'b1);
        run_fn(6'h0d, 24'h004000, 1'b1);
        run_fn(6'h0d, 24'h002000, 1'b1);
        run_fn(6'h0e, 24'h001800, 1'b1);
        run_fn(6'h0e, 24'h001c00, 1'b0);
        run_fn(6'h0f, 24'h000000, 1'b1);
        run_fn(6'h0f, 24'h001000, 1'b0);
        run_fn(6'h10, 24'h001800, 1'b1);
        run_fn(6'h10, 24'h001a00, 1'b0);
        run_fn(6'h11, 24'h000080, 1'b1);
        run_fn(6'h12, 24'h000040, 1'b1);
        run_fn(6'h13, 24'h000020, 1'b1);
        run_fn(6'h16, 24'h000010, 1'b1);
        run_fn(6'h1d, 24'h000004, 1'b1);
        run_fn(6'h23, 24'h000002, 1'b1);
        run_fn(6'h28, 24'h000001, 1'b1);
        run_fn(6'h00, 24'hffffff, 1'b0);
        run_fn(6'h03, 24'hffffff, 1'b0);
        run_fn(6'h14, 24'hffffff, 1'b0);
        apb(1'b1, 12'h010, 32'h5);
        set_sel(6'h1c);
        wait_out(24'h000000, 12'h000, 5, 3'b000);
        wait_out(24'h000008, 12'h000, 4, 3'b000);
        wait_out(24'h000008, 12'h000, 12, 3'b111);
        wait_out(24'h000000, 12'h000, 5, 3'b000);
        set_sel(6'h22);
        wait_out(24'h000000, 12'h300, 8, 3'b000);
        wait_out(24'h000000, 12'h800, 8, 3'b111);
        wait_out(24'h000000, 12'h600, 8, 3'b111);
        wait_out(24'h000000, 12'h400, 8, 3'b000);
        wait_out(24'h000000, 12'h7ff, 8, 3'b000);
        apb(1'b1, 12'h000, 32'h05);
        apb(1'b1, 12'h004, 32'h06);
        apb(1'b1, 12'h008, 32'h07);
        wait_out(24'h800000, 12'h000, 5, 3'b001);
        wait_out(24'h600000, 12'h000, 5, 3'b110);
        rdchk(12'h00c, 32'h6);
        stop_test();
    end
endmodule

bind ofs_output_function_selector ofs_checker u_ofs_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .relay1_out(relay1_out), .relay2_out(relay2_out),
    .transistor_output(transistor_output));
